// *** rtl/mil_consts.svh ***
// register indices, field positions and reset values of the interrupt logic
// Function
// - four request sources: edge pin, timer overflow, port change, comparator
// - global enable at control bit 7 passes unmasked requests, else blocks
// - every reset clears the global enable
// - return instruction pops return address and sets the global enable
// - comparator flag and enable live in separate peripheral registers
// - taking a request clears global enable, pushes pc, vectors to 0004h
// - pin and port-change events reach the vector in three or four cycles
// - flags set on their event regardless of any enable bit
// - clearing global enable blocks next-cycle requests, inserts an idle cycle
// - edge pin rising when option bit 6 set, falling when clear
// - valid pin edge sets control bit 1; enable at control bit 4
// - pin wakes only if enabled before sleep; global enable picks vector
// - timer rollover sets control bit 2, gated by control bit 5
// - change on upper port pins sets control bit 0, gated by its enable
// - a change racing a port read may not set the change flag
// - entry saves only the return pc, nothing else
// - wake, global enable clear: run on; set: run one, then vector
// - sleeping with an enabled flag set wakes at once, global enable or not
`ifndef MIL_CONSTS_SVH
`define MIL_CONSTS_SVH
`define MIL_IDX_CTRL 10'h00B
`define MIL_IDX_PFLAG 10'h00C
`define MIL_IDX_OPT 10'h081
`define MIL_IDX_PEN 10'h08C
`define MIL_CTRL_RST 8'h00
`define MIL_PREG_RST 8'h00
`define MIL_OPT_RST 8'hFF
`define MIL_B_GLB_EN 7
`define MIL_B_PEIE 6
`define MIL_B_TIE 5
`define MIL_B_EIE 4
`define MIL_B_PCIE 3
`define MIL_B_TIF 2
`define MIL_B_EIF 1
`define MIL_B_PCIF 0
`define MIL_B_EDGE 6
`define MIL_B_CMP 6
`define MIL_VECTOR 16'h0004
`define MIL_PRIME_CYC 2'h3
`define MIL_RESP_OK 2'h0
`define MIL_RESP_ERR 2'h2
`endif

// *** rtl/mil_pkg.sv ***
// types and decode helpers shared by the interrupt logic modules
`default_nettype none
`include "mil_consts.svh"
package mil_pkg;
  typedef logic [9:0] mil_idx_t;
  typedef enum logic [0:0] {
    mil_pwr_run = 1'b0,
    mil_pwr_sleep = 1'b1
  } mil_pwr_t;
  // true for every register index that answers on the bus
  function automatic logic mil_mapped(input mil_idx_t idx);
    mil_mapped = (idx == `MIL_IDX_CTRL) || (idx == `MIL_IDX_PFLAG) ||
                 (idx == `MIL_IDX_OPT) || (idx == `MIL_IDX_PEN);
  endfunction
endpackage
`default_nettype wire

// *** rtl/mil_reg_if.sv ***
// register access path between bus slave and interrupt register file
`default_nettype none
interface mil_reg_if;
  import mil_pkg::*;
  logic wr_en;
  mil_idx_t wr_idx;
  logic [7:0] wr_data;
  mil_idx_t rd_idx;
  logic [7:0] rd_data;
  modport slv (output wr_en, output wr_idx, output wr_data,
               output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data,
                input rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** rtl/mil_pin_sync.sv ***
// two-stage synchroniser for pins arriving from outside the clock domain
`default_nettype none
module mil_pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pin side and synchronised side
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  initial begin
    if (W < 1) $error("mil_pin_sync: W must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= pin;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// *** rtl/mil_axil_slave.sv ***
// axi4-lite slave giving byte-wide access to the interrupt registers
`default_nettype none
`include "mil_consts.svh"
module mil_axil_slave #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  mil_reg_if.slv rb
);
  import mil_pkg::*;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_take;
  logic ar_take;

  initial begin
    if (ADDR_W < 12) $error("mil_axil_slave: ADDR_W below 12");
  end

  // address and data are taken together, only when no response is owed
  assign aw_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign s_axi_awready = aw_take;
  assign s_axi_wready = aw_take;
  assign rb.wr_idx = s_axi_awaddr[11:2];
  assign rb.wr_data = s_axi_wdata[7:0];
  // only lane 0 carries register bits; upper lanes are ignored
  assign rb.wr_en = aw_take & s_axi_wstrb[0] & mil_mapped(rb.wr_idx);
  assign ar_take = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_arready = ar_take;
  assign rb.rd_idx = s_axi_araddr[11:2];

  // write response one cycle after the take
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `MIL_RESP_OK;
    end else if (aw_take) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mil_mapped(rb.wr_idx) ? `MIL_RESP_OK : `MIL_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read data registered at the take; unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `MIL_RESP_OK;
      rdata_ff <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mil_mapped(rb.rd_idx) ? `MIL_RESP_OK : `MIL_RESP_ERR;
      rdata_ff <= {24'h00_0000, rb.rd_data};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule
`default_nettype wire

// *** rtl/mil_irq_top.sv ***
// interrupt logic: flags, enables, core request, entry and power-down wake
`default_nettype none
`include "mil_consts.svh"
module mil_irq_top #(
  parameter int PC_W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request sources
  input wire logic ext_irq_pin,
  input wire logic [3:0] second_io_port_hi,
  input wire logic timer_ovf_evt,
  input wire logic cmp_change_evt,
  // processor core sequencer
  input wire logic irq_take,
  input wire logic return_from_irq_instr,
  input wire logic sleep_instr,
  input wire logic [PC_W-1:0] ret_pc,
  output logic irq_req,
  output logic [PC_W-1:0] vector_pc,
  output logic push_req,
  output logic [PC_W-1:0] push_pc,
  output logic pop_req,
  output logic no_operation_cycle,
  // power-down status
  output logic asleep,
  output logic wake_evt,
  output logic wake_to_vector,
  output logic global_irq_enable
);
  import mil_pkg::*;

  mil_reg_if rb();

  // synchronised pins and edge history
  logic ext_sync;
  logic [3:0] port_sync;
  logic ext_prev_ff;
  logic [3:0] port_prev_ff;
  logic [1:0] prime_ff;
  logic primed;
  logic ext_evt;
  logic port_evt;

  // control, option and comparator register bits
  logic glb_en_ff;
  logic peie_ff;
  logic tie_ff;
  logic eie_ff;
  logic pcie_ff;
  logic tif_ff;
  logic eif_ff;
  logic pcif_ff;
  logic [7:0] opt_ff;
  logic cmpf_ff;
  logic cmpe_ff;

  // core handshake and power state
  logic irq_req_ff;
  logic push_req_ff;
  logic [PC_W-1:0] push_pc_ff;
  logic [PC_W-1:0] vector_ff;
  logic pop_req_ff;
  logic idle_slot_ff;
  mil_pwr_t pwr_ff;
  mil_pwr_t nxt_pwr;
  logic eie_at_sleep_ff;
  logic wake_evt_ff;
  logic wake_vec_ff;

  // decode and combined terms
  logic wr_ctrl;
  logic wr_pflag;
  logic wr_pen;
  logic wr_opt;
  logic take;
  logic glb_en_clr;
  logic nxt_glb_en;
  logic pending;
  logic wake_cond;

  initial begin
    if (PC_W < 3 || PC_W > 16) $error("mil_irq_top: PC_W out of range");
  end

  // register bus slave
  mil_axil_slave #(
    .ADDR_W(12)
  ) u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb.slv)
  );

  // the edge pin and the upper port pins come from outside this clock
  mil_pin_sync #(
    .W(5)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin({second_io_port_hi, ext_irq_pin}),
    .q({port_sync, ext_sync})
  );

  // after reset, history is loaded for a few cycles before edges count,
  // so a pin that simply sits high is not mistaken for an edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prime_ff <= 2'h0;
    end else if (!primed) begin
      prime_ff <= prime_ff + 2'h1;
    end
  end
  assign primed = (prime_ff == `MIL_PRIME_CYC);

  // pin history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_prev_ff <= 1'b0;
      port_prev_ff <= 4'h0;
    end else begin
      ext_prev_ff <= ext_sync;
      port_prev_ff <= port_sync;
    end
  end

  // edge select picks rising or falling on the edge pin
  assign ext_evt = primed & (opt_ff[`MIL_B_EDGE] ?
                   (ext_sync & ~ext_prev_ff) :
                   (~ext_sync & ext_prev_ff));
  // any of the four pins differing from its last sample; a change that
  // lands exactly on a software port read has no guaranteed outcome
  assign port_evt = primed & (port_sync != port_prev_ff);

  // register write decode
  assign wr_ctrl = rb.wr_en & (rb.wr_idx == `MIL_IDX_CTRL);
  assign wr_pflag = rb.wr_en & (rb.wr_idx == `MIL_IDX_PFLAG);
  assign wr_pen = rb.wr_en & (rb.wr_idx == `MIL_IDX_PEN);
  assign wr_opt = rb.wr_en & (rb.wr_idx == `MIL_IDX_OPT);

  // a request is only taken while it is being offered
  assign take = irq_take & irq_req_ff;
  // software turning the global enable off
  assign glb_en_clr = wr_ctrl & glb_en_ff & ~rb.wr_data[`MIL_B_GLB_EN];

  // exactly four sources, each flag gated by its own enable;
  // the comparator also needs the peripheral group enable
  assign pending = (eif_ff & eie_ff) |
                   (tif_ff & tie_ff) |
                   (pcif_ff & pcie_ff) |
                   (peie_ff & cmpf_ff & cmpe_ff);

  // global enable: entry clears, return sets, software writes
  always_comb begin
    nxt_glb_en = glb_en_ff;
    if (take) begin
      nxt_glb_en = 1'b0;
    end else if (return_from_irq_instr) begin
      nxt_glb_en = 1'b1;
    end else if (wr_ctrl) begin
      nxt_glb_en = rb.wr_data[`MIL_B_GLB_EN];
    end
  end

  // global enable flop; any reset leaves interrupts off
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      glb_en_ff <= 1'b0;
    end else begin
      glb_en_ff <= nxt_glb_en;
    end
  end

  // enable bits are plain software state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      peie_ff <= 1'b0;
      tie_ff <= 1'b0;
      eie_ff <= 1'b0;
      pcie_ff <= 1'b0;
    end else if (wr_ctrl) begin
      peie_ff <= rb.wr_data[`MIL_B_PEIE];
      tie_ff <= rb.wr_data[`MIL_B_TIE];
      eie_ff <= rb.wr_data[`MIL_B_EIE];
      pcie_ff <= rb.wr_data[`MIL_B_PCIE];
    end
  end

  // flags set on their event whatever the enables say; a hardware set
  // in the same cycle as a software clear wins, so no event is lost
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tif_ff <= 1'b0;
      eif_ff <= 1'b0;
      pcif_ff <= 1'b0;
    end else begin
      tif_ff <= (wr_ctrl ? rb.wr_data[`MIL_B_TIF] : tif_ff) |
                timer_ovf_evt;
      eif_ff <= (wr_ctrl ? rb.wr_data[`MIL_B_EIF] : eif_ff) |
                ext_evt;
      pcif_ff <= (wr_ctrl ? rb.wr_data[`MIL_B_PCIF] : pcif_ff) |
                 port_evt;
    end
  end

  // comparator flag and enable sit in their own registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmpf_ff <= 1'b0;
      cmpe_ff <= 1'b0;
    end else begin
      cmpf_ff <= (wr_pflag ? rb.wr_data[`MIL_B_CMP] : cmpf_ff) |
                 cmp_change_evt;
      if (wr_pen) begin
        cmpe_ff <= rb.wr_data[`MIL_B_CMP];
      end
    end
  end

  // option register is held whole; only the edge select is used here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opt_ff <= `MIL_OPT_RST;
    end else if (wr_opt) begin
      opt_ff <= rb.wr_data;
    end
  end

  // request to the core, registered: pin event to request is four
  // edges, which with the core's sample lands the vector in 3 to 4
  // cycles; the cycle after the enable is cleared offers nothing, and
  // a pending request simply waits until the enable comes back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_req_ff <= 1'b0;
    end else begin
      irq_req_ff <= nxt_glb_en & pending & ~glb_en_clr &
                    (nxt_pwr == mil_pwr_run);
    end
  end

  // idle slot in the cycle after software clears the global enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_slot_ff <= 1'b0;
    end else begin
      idle_slot_ff <= glb_en_clr;
    end
  end

  // entry pushes only the return pc and loads the fixed vector;
  // working and status registers are left to software
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      push_req_ff <= 1'b0;
      push_pc_ff <= '0;
      vector_ff <= '0;
    end else begin
      push_req_ff <= take;
      if (take) begin
        push_pc_ff <= ret_pc;
        vector_ff <= PC_W'(`MIL_VECTOR);
      end
    end
  end

  // return instruction pops the saved pc
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pop_req_ff <= 1'b0;
    end else begin
      pop_req_ff <= return_from_irq_instr;
    end
  end

  // wake needs a set flag with its enable; global enable plays no
  // part. the pin uses the enable as it stood when power-down began
  assign wake_cond = (eif_ff & eie_at_sleep_ff) |
                     (tif_ff & tie_ff) |
                     (pcif_ff & pcie_ff) |
                     (peie_ff & cmpf_ff & cmpe_ff);

  // power state; a source already pending at entry wakes one cycle
  // later, after the power-down instruction itself has finished
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      mil_pwr_run: begin
        if (sleep_instr) begin
          nxt_pwr = mil_pwr_sleep;
        end
      end
      mil_pwr_sleep: begin
        if (wake_cond) begin
          nxt_pwr = mil_pwr_run;
        end
      end
    endcase
  end

  // power state flop and pin enable snapshot
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_ff <= mil_pwr_run;
      eie_at_sleep_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      if (pwr_ff == mil_pwr_run && sleep_instr) begin
        eie_at_sleep_ff <= eie_ff;
      end
    end
  end

  // wake pulse; with global enable set the core runs the prefetched
  // instruction and then sees the request, with it clear it continues
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_evt_ff <= 1'b0;
      wake_vec_ff <= 1'b0;
    end else begin
      wake_evt_ff <= (pwr_ff == mil_pwr_sleep) & wake_cond;
      if ((pwr_ff == mil_pwr_sleep) && wake_cond) begin
        wake_vec_ff <= glb_en_ff;
      end
    end
  end

  // register readback shows live flags and enables
  always_comb begin
    rb.rd_data = 8'h00;
    if (rb.rd_idx == `MIL_IDX_CTRL) begin
      rb.rd_data = {glb_en_ff, peie_ff, tie_ff, eie_ff,
                    pcie_ff, tif_ff, eif_ff, pcif_ff};
    end else if (rb.rd_idx == `MIL_IDX_PFLAG) begin
      rb.rd_data = `MIL_PREG_RST;
      rb.rd_data[`MIL_B_CMP] = cmpf_ff;
    end else if (rb.rd_idx == `MIL_IDX_PEN) begin
      rb.rd_data = `MIL_PREG_RST;
      rb.rd_data[`MIL_B_CMP] = cmpe_ff;
    end else if (rb.rd_idx == `MIL_IDX_OPT) begin
      rb.rd_data = opt_ff;
    end
  end

  // outputs
  assign irq_req = irq_req_ff;
  assign vector_pc = vector_ff;
  assign push_req = push_req_ff;
  assign push_pc = push_pc_ff;
  assign pop_req = pop_req_ff;
  assign no_operation_cycle = idle_slot_ff;
  assign asleep = (pwr_ff == mil_pwr_sleep);
  assign wake_evt = wake_evt_ff;
  assign wake_to_vector = wake_vec_ff;
  assign global_irq_enable = glb_en_ff;
endmodule
`default_nettype wire

// *** tb/mil_irq_top_props.sv ***
// assertions on the ports of the interrupt logic top
`default_nettype none
`include "mil_consts.svh"
module mil_irq_top_props #(
  parameter int PC_W = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // core sequencer side
  input wire logic irq_take,
  input wire logic return_from_irq_instr,
  input wire logic sleep_instr,
  input wire logic [PC_W-1:0] ret_pc,
  // request, stack and power-down outputs
  input wire logic irq_req,
  input wire logic [PC_W-1:0] vector_pc,
  input wire logic push_req,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic pop_req,
  input wire logic no_operation_cycle,
  input wire logic asleep,
  input wire logic wake_evt,
  input wire logic wake_to_vector,
  input wire logic global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // a take vectors and drops the global enable in the very next cycle
  property p_entry;
    irq_take && irq_req |=> push_req && !global_irq_enable &&
      vector_pc == PC_W'(`MIL_VECTOR);
  endproperty
  a_entry: assert property (p_entry) else $error("no vector");
  // only the return pc is stacked, once, and the request then drops
  property p_saved;
    irq_take && irq_req |=> push_pc == $past(ret_pc) ##1 !push_req && !irq_req;
  endproperty
  a_saved: assert property (p_saved) else $error("bad push");
  property p_return;
    return_from_irq_instr |=> pop_req && global_irq_enable ##1 !pop_req;
  endproperty
  a_return: assert property (p_return) else $error("bad return");
  // the idle cycle after the enable is cleared must not offer a request
  property p_idle;
    no_operation_cycle |-> !irq_req ##1 !no_operation_cycle;
  endproperty
  a_idle: assert property (p_idle) else $error("req in idle cycle");
  property p_cause;
    $rose(irq_req) |-> global_irq_enable && !asleep;
  endproperty
  a_cause: assert property (p_cause) else $error("req, enable off");
  property p_sleep;
    sleep_instr |=> asleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  // wake comes only out of sleep and records the enable for branching
  property p_wake;
    wake_evt |-> !asleep && $past(asleep) &&
      wake_to_vector == global_irq_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_quiet;
    asleep |-> !irq_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("req asleep");
endmodule
bind mil_irq_top mil_irq_top_props #(.PC_W(PC_W)) u_props (
  .mclk, .rst_n, .irq_take, .return_from_irq_instr, .sleep_instr, .ret_pc,
  .irq_req, .vector_pc, .push_req, .push_pc, .pop_req, .no_operation_cycle,
  .asleep, .wake_evt, .wake_to_vector, .global_irq_enable
);
`default_nettype wire

// *** tb/mil_core_model.sv ***
// core sequencer stand-in: takes offered requests and stays busy until the return instruction
`default_nettype none
module mil_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // interrupt link
  input wire logic irq_req,
  input wire logic ret_instr,
  input wire logic [1:0] dly,
  output logic irq_take,
  output logic [12:0] ret_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_ff;
  logic [1:0] cnt_ff;
  // take after dly waiting cycles; busy blocks a second take because
  // irq_req lingers one cycle after the take
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_take <= 1'h0;
      busy_ff <= 1'h0;
      cnt_ff <= 2'h0;
      ret_pc <= 13'h0100;
    end else begin
      irq_take <= 1'h0;
      if (ret_instr) busy_ff <= 1'h0;
      if (irq_take) begin
        busy_ff <= 1'h1;
        ret_pc <= ret_pc + 13'h0001;
      end else if (irq_req && !busy_ff) begin
        cnt_ff <= (cnt_ff == dly) ? 2'h0 : cnt_ff + 2'h1;
        irq_take <= (cnt_ff == dly);
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/mil_irq_top_bench.sv ***
// self-checking bench of the interrupt logic
`default_nettype none
`include "mil_consts.svh"
module mil_irq_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdat;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic ext_pin = 1'h0;
  logic [3:0] pv = 4'h0, port_hi = 4'h0, seen = 4'h0;
  logic [1:0] dly = 2'h0, resp;
  int fails = 0, n_compared = 0, n;
  wire awready, wready, bvalid, arready, rvalid, take, irq_req, push, pop;
  wire idle, asleep, wake, wvec, glb_en;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] rpc, vpc, ppc;
  always #2 mclk = ~mclk;
  mil_irq_top dut (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_pin(ext_pin),
    .second_io_port_hi(port_hi), .timer_ovf_evt(pv[0]),
    .cmp_change_evt(pv[1]), .irq_take(take), .return_from_irq_instr(pv[2]),
    .sleep_instr(pv[3]), .ret_pc(rpc), .irq_req(irq_req), .vector_pc(vpc),
    .push_req(push), .push_pc(ppc), .pop_req(pop),
    .no_operation_cycle(idle), .asleep(asleep), .wake_evt(wake),
    .wake_to_vector(wvec), .global_irq_enable(glb_en));
  mil_core_model core (.mclk(mclk), .rst_n(rst_n), .irq_req(irq_req),
    .ret_instr(pv[2]), .dly(dly), .irq_take(take), .ret_pc(rpc));
  // sticky record of one-cycle pulses so that no check can miss them
  always @(posedge mclk) seen <= seen | {pop, wake, idle, push};
  // wide enough for a response code beside a full data word
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  // address and data go out together; each drops at the edge it is taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic a, w, b;
    b = 1'h0;
    @(posedge mclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      @(negedge mclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge mclk);
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) bready <= 1'h0;
    end
  endtask
  task automatic rd(input logic [9:0] idx);
    logic a, b;
    b = 1'h0;
    @(posedge mclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!b) begin
      @(negedge mclk);
      a = arvalid && arready;
      b = rvalid && rready;
      rdat = rdata;
      resp = rresp;
      @(posedge mclk);
      if (a) arvalid <= 1'h0;
      if (b) rready <= 1'h0;
    end
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    rd(idx);
    chk({resp, rdat}, {2'h0, 24'h0, e});
  endtask
  // one-cycle pulse on event input b: timer, comparator, return, sleep
  task automatic pls(input int b);
    @(posedge mclk);
    pv[b] <= 1'h1;
    @(posedge mclk);
    pv[b] <= 1'h0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wseen(input int b);
    for (int k = 0; k < 20 && !seen[b]; k++) @(posedge mclk);
  endtask
  task automatic clr;
    @(negedge mclk);
    seen = 4'h0;
  endtask
  task automatic edge_at(input logic v);
    @(posedge mclk);
    ext_pin <= v;
    cyc(6);
  endtask
  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    rdc(`MIL_IDX_CTRL, 8'h00);
    rdc(`MIL_IDX_OPT, 8'hFF);
    rdc(`MIL_IDX_PFLAG, 8'h00);
    rdc(`MIL_IDX_PEN, 8'h00);
    rd(10'h3FF);
    chk({resp, rdat}, {`MIL_RESP_ERR, 32'h0});
    wr(10'h3FF, 8'h55);
    chk(resp, `MIL_RESP_ERR);
    $display("test registers done");
    pls(0);
    pls(1);
    cyc(2);
    chk(irq_req, 1'h0);
    rdc(`MIL_IDX_CTRL, 8'h04);
    rdc(`MIL_IDX_PFLAG, 8'h40);
    wr(`MIL_IDX_PFLAG, 8'h00);
    $display("test flags done");
    wr(`MIL_IDX_CTRL, 8'h90);
    @(posedge mclk);
    ext_pin <= 1'h1;
    n = 0;
    @(negedge mclk);
    while (!irq_req && n < 9) begin
      @(negedge mclk);
      n++;
    end
    chk(n >= 3 && n <= 4, 1'h1);
    wseen(0);
    chk({vpc, ppc}, {`MIL_VECTOR, 13'h0100});
    rdc(`MIL_IDX_CTRL, 8'h12);
    clr;
    dly <= 2'h2;
    pls(2);
    wseen(0);
    chk({seen[3], ppc}, {1'h1, 13'h0101});
    wr(`MIL_IDX_CTRL, 8'h10);
    clr;
    pls(2);
    cyc(6);
    chk({seen[3], irq_req, glb_en}, 3'h5);
    $display("test entry done");
    wr(`MIL_IDX_OPT, 8'hBF);
    wr(`MIL_IDX_CTRL, 8'h00);
    edge_at(1'h0);
    rdc(`MIL_IDX_CTRL, 8'h02);
    wr(`MIL_IDX_CTRL, 8'h00);
    edge_at(1'h1);
    rdc(`MIL_IDX_CTRL, 8'h00);
    @(posedge mclk);
    port_hi <= 4'h5;
    cyc(6);
    rdc(`MIL_IDX_CTRL, 8'h01);
    wr(`MIL_IDX_CTRL, 8'h80);
    clr;
    wr(`MIL_IDX_CTRL, 8'h08);
    cyc(1);
    chk(seen[1], 1'h1);
    @(posedge mclk);
    port_hi <= 4'hA;
    cyc(6);
    chk(irq_req, 1'h0);
    rdc(`MIL_IDX_CTRL, 8'h09);
    $display("test edges done");
    clr;
    pls(3);
    wseen(2);
    chk({seen[2], wvec, asleep}, 3'h4);
    wr(`MIL_IDX_CTRL, 8'h00);
    clr;
    pls(3);
    edge_at(1'h0);
    cyc(2);
    chk({seen[2], asleep}, 2'h1);
    wr(`MIL_IDX_CTRL, 8'hA0);
    pls(0);
    wseen(2);
    wseen(0);
    chk({seen[2], wvec, ppc}, {2'h3, 13'h0102});
    $display("test sleep done");
    wr(`MIL_IDX_PEN, 8'h40);
    wr(`MIL_IDX_CTRL, 8'h40);
    pls(2);
    clr;
    pls(1);
    wseen(0);
    chk({seen[0], ppc}, {1'h1, 13'h0103});
    rdc(`MIL_IDX_PEN, 8'h40);
    $display("test comparator done");
    report_and_stop;
  end
  // the sequence needs well under a thousand cycles; this marks a hang
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    $display("mismatch at %0t: timeout", $time);
    report_and_stop;
  end
endmodule
`default_nettype wire
